// *** design/dcb_pkg.sv ***
// Shared constants, encodings and state records of the DAC channel control bank.
// Assumes one 8-bit register port in the core domain and one audio link clock.
package dcb_pkg;

    // Register byte addresses on the control port
    localparam logic [6:0] A_CTL1 = 7'h41;
    localparam logic [6:0] A_CTL2 = 7'h42;
    localparam logic [6:0] A_PHASE = 7'h43;
    localparam logic [6:0] A_MUTE = 7'h44;
    localparam logic [6:0] A_ZERO = 7'h45;
    localparam logic [6:0] A_CTL3 = 7'h46;

    // Values after reset
    localparam logic [7:0] RST_CTL1 = 8'h00;
    localparam logic [7:0] RST_CTL2 = 8'h00;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_MUTE = 8'h00;
    localparam logic [7:0] RST_CTL3 = 8'h00;
    localparam logic [7:0] CTL1_MASK = 8'h8F;

    // Field positions
    localparam int CTL1_PS_BIT = 7;
    localparam int CTL1_FMT_LSB = 0;
    localparam int CTL2_DIS_LSB = 4;
    localparam int CTL2_FLT_LSB = 0;
    localparam int CTL3_MODE_BIT = 7;
    localparam int CTL3_SPEED_BIT = 6;
    localparam int CTL3_DEEMPHASIS_SELECT_LSB = 4;
    localparam int CTL3_PINFN_LSB = 1;
    localparam int CTL3_POL_BIT = 0;

    // Attenuator codes and ramp timing, in sample periods
    localparam logic [7:0] ATT_FULL = 8'hFF;
    localparam logic [7:0] ATT_ZERO = 8'h00;
    localparam logic [8:0] ATT_SUM_BIAS = 9'h0FF;
    localparam int ATT_CODES = 256;
    localparam int ATT_RAMP_BASE = 2048;

    typedef logic [7:0] dcb_code_t;

    typedef enum logic [3:0] {
        FMT_I2S = 4'h0,
        FMT_LJ = 4'h1,
        FMT_RJ24 = 4'h2,
        FMT_RJ16 = 4'h3,
        FMT_DSP_I2S = 4'h4,
        FMT_DSP_LJ = 4'h5,
        FMT_TDM_I2S = 4'h6,
        FMT_TDM_LJ = 4'h7,
        FMT_HTDM_I2S = 4'h8,
        FMT_HTDM_LJ = 4'h9
    } dcb_fmt_e;
    localparam logic [3:0] FMT_RSVD_MIN = 4'hA;

    typedef enum logic [1:0] {
        RATE_AUTO = 2'h0,
        RATE_SINGLE = 2'h1,
        RATE_DUAL = 2'h2,
        RATE_QUAD = 2'h3
    } dcb_rate_e;

    typedef enum logic [2:0] {
        RATIO_128 = 3'h0,
        RATIO_192 = 3'h1,
        RATIO_256 = 3'h2,
        RATIO_384 = 3'h3,
        RATIO_512 = 3'h4,
        RATIO_768 = 3'h5
    } dcb_ratio_e;

    typedef enum logic [3:0] {
        P_RUN = 4'b0001,
        P_FADE_OUT = 4'b0010,
        P_OFF = 4'b0100,
        P_FADE_IN = 4'b1000
    } dcb_pair_e;

    typedef struct packed {
        logic rst_a;
        logic rst_b;
        logic rst_c;
        logic tgl;
        logic [7:0] zero;
    } dcb_link_s;

    typedef struct packed {
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] phase;
        logic [7:0] mute;
        logic [7:0] ctl3;
        logic [7:0] zero_stat;
        logic [7:0] z_a;
        logic [7:0] z_b;
        logic [7:0] z_c;
        logic tg_a;
        logic tg_b;
        logic tg_c;
        logic tg_seen;
        logic [7:0] step_cnt;
        dcb_code_t [7:0] cur;
        dcb_code_t [7:0] tgt;
        dcb_pair_e [3:0] pair;
        logic [7:0] rdata;
        logic rvalid;
        logic pin;
    } dcb_core_s;

endpackage : dcb_pkg

// *** design/dcb_bank.sv ***
// DAC channel control bank: format, pair disable with fades, roll-off, phase,
// soft mute and attenuation ramps, zero flags and zero-flag pin.
// Assumes a decoded serial control port (one byte per access) in the core
// domain, and audio link logic on link_clk_i giving a frame pulse and zero flags.
`timescale 1ns/1ps
module dcb_bank #(
    parameter int unsigned RAMP_SAMPLES = dcb_pkg::ATT_RAMP_BASE
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic link_clk_i,
    input wire logic link_frame_i,
    input wire logic [7:0] zero_det_i,
    input wire logic mode_reset_i,
    input wire dcb_pkg::dcb_rate_e dac_rate_mode_i,
    input wire dcb_pkg::dcb_ratio_e clk_ratio_i,
    input wire dcb_pkg::dcb_code_t [8:0] dac_atten_level_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output dcb_pkg::dcb_fmt_e dac_format_select_o,
    output logic dac_powersave_select_o,
    output logic [3:0] rolloff_select_o,
    output logic [7:0] dac_phase_invert_o,
    output logic [1:0] deemphasis_select_o,
    output dcb_pkg::dcb_code_t [7:0] dac_atten_gain_o,
    output logic [3:0] pair_off_o,
    output logic [3:0] dac_common_mode_level_o,
    output logic [3:0] dac_analog_ground_o,
    output logic [3:0] pair_power_down_o,
    output logic silence_pin_o
);
    import dcb_pkg::*;

    localparam logic [7:0] STEP_BASE = 8'(RAMP_SAMPLES / ATT_CODES);

    // Step counter is 8 bits wide and must hold base * 4 * 2
    if (RAMP_SAMPLES % ATT_CODES != 0 || RAMP_SAMPLES / ATT_CODES > 31
        || RAMP_SAMPLES < ATT_CODES) begin : g_bad_ramp
        $error("RAMP_SAMPLES must be a multiple of 256 between 256 and 7936");
    end

    dcb_link_s l;
    dcb_link_s next_l;
    dcb_core_s q;
    dcb_core_s next_q;

    logic tick;
    logic step_due;
    logic [1:0] nshift;
    logic [7:0] step_len;
    dcb_code_t [7:0] desired;

    // Link side: frame events become a toggle, zero flags are registered
    always_comb begin
        next_l = l;
        next_l.rst_a = sys_rst_i;
        next_l.rst_b = l.rst_a;
        next_l.rst_c = l.rst_b;
        if (l.rst_b && l.rst_c) begin
            next_l.tgl = 1'b0;
            next_l.zero = 8'h00;
        end else begin
            next_l.tgl = l.tgl ^ link_frame_i;
            next_l.zero = zero_det_i;
        end
    end

    always_ff @(posedge link_clk_i) begin
        l <= next_l;
    end

    always_comb begin
        // Locals first
        logic [8:0] sum9;
        logic [7:0] agree;
        dcb_code_t lvl;
        logic dis;
        logic forced;
        logic settle;
        logic any_z;
        logic det;
        sum9 = 9'h000;
        agree = 8'h00;
        lvl = ATT_ZERO;
        dis = 1'b0;
        forced = 1'b0;
        settle = 1'b0;
        any_z = 1'b0;
        det = 1'b0;
        next_q = q;
        desired = '0;

        // Three-stage crossing of the frame toggle; counts once stages 2 and 3 agree
        next_q.tg_a = l.tgl;
        next_q.tg_b = q.tg_a;
        next_q.tg_c = q.tg_b;
        tick = (q.tg_b == q.tg_c) && (q.tg_c != q.tg_seen);
        if (tick) begin
            next_q.tg_seen = q.tg_c;
        end

        next_q.z_a = l.zero;
        next_q.z_b = q.z_a;
        next_q.z_c = q.z_b;
        agree = ~(q.z_b ^ q.z_c);
        next_q.zero_stat = (agree & q.z_c) | (~agree & q.zero_stat);

        case (dac_rate_mode_i)
            RATE_SINGLE: nshift = 2'd0;
            RATE_DUAL: nshift = 2'd1;
            RATE_QUAD: nshift = 2'd2;
            default: begin
                case (clk_ratio_i)
                    RATIO_512, RATIO_768: nshift = 2'd0;
                    RATIO_256, RATIO_384: nshift = 2'd1;
                    default: nshift = 2'd2;
                endcase
            end
        endcase

        // One code step per base*N*(1 or 2) samples spans the full ramp
        step_len = STEP_BASE << (nshift + {1'b0, q.ctl3[CTL3_SPEED_BIT]});
        step_due = tick && (q.step_cnt >= step_len - 8'h01);
        if (tick) begin
            next_q.step_cnt = step_due ? 8'h00 : q.step_cnt + 8'h01;
        end

        // Desired attenuator code per channel
        for (int i = 0; i < 8; i++) begin
            // Master plus own in decibels, floor at the mute code
            sum9 = {1'b0, dac_atten_level_i[0]} + {1'b0, dac_atten_level_i[i + 1]};
            if (q.ctl3[CTL3_MODE_BIT]) begin
                lvl = (sum9 < ATT_SUM_BIAS) ? ATT_ZERO : 8'(sum9 - ATT_SUM_BIAS);
            end else begin
                lvl = dac_atten_level_i[i + 1];
            end
            forced = (q.pair[i / 2] == P_FADE_OUT) || (q.pair[i / 2] == P_OFF);
            // Mute and pair fade override the programmed level
            desired[i] = (q.mute[i] || forced) ? ATT_ZERO : lvl;
        end

        // Pair sequencing
        for (int p = 0; p < 4; p++) begin
            dis = q.ctl2[CTL2_DIS_LSB + p];
            settle = (q.cur[2 * p] == desired[2 * p])
                && (q.cur[2 * p + 1] == desired[2 * p + 1]);
            case (q.pair[p])
                P_RUN: begin
                    if (dis) begin
                        next_q.pair[p] = P_FADE_OUT;
                    end
                end
                P_FADE_OUT: begin
                    if (!dis) begin
                        next_q.pair[p] = P_FADE_IN;
                    end else if (q.cur[2 * p] == ATT_ZERO && q.cur[2 * p + 1] == ATT_ZERO) begin
                        next_q.pair[p] = P_OFF;
                    end
                end
                P_OFF: begin
                    if (!dis) begin
                        next_q.pair[p] = P_FADE_IN;
                    end
                end
                P_FADE_IN: begin
                    if (dis) begin
                        next_q.pair[p] = P_FADE_OUT;
                    end else if (settle) begin
                        next_q.pair[p] = P_RUN;
                    end
                end
                default: next_q.pair[p] = P_RUN;
            endcase
        end

        // Ramp engine; a new target is taken only when the last one is reached
        for (int i = 0; i < 8; i++) begin
            if (q.pair[i / 2] == P_OFF) begin
                // Internal data of a stopped pair held cleared
                next_q.cur[i] = ATT_ZERO;
                next_q.tgt[i] = ATT_ZERO;
            end else if (q.cur[i] == q.tgt[i]) begin
                next_q.tgt[i] = desired[i];
            end else if (step_due) begin
                next_q.cur[i] = (q.cur[i] < q.tgt[i]) ? q.cur[i] + 8'h01 : q.cur[i] - 8'h01;
            end
        end

        case (q.ctl3[CTL3_PINFN_LSB +: 3])
            3'h1: det = &q.zero_stat[1:0];
            3'h2: det = &q.zero_stat[3:2];
            3'h3: det = &q.zero_stat[5:4];
            3'h4: det = &q.zero_stat[7:6];
            default: det = &q.zero_stat;
        endcase
        any_z = det;
        next_q.pin = any_z ^ q.ctl3[CTL3_POL_BIT];

        // Register read, answered one cycle later
        next_q.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            case (reg_addr_i)
                A_CTL1: next_q.rdata = q.ctl1 & CTL1_MASK;
                A_CTL2: next_q.rdata = q.ctl2;
                A_PHASE: next_q.rdata = q.phase;
                A_MUTE: next_q.rdata = q.mute;
                A_ZERO: next_q.rdata = q.zero_stat;
                A_CTL3: next_q.rdata = q.ctl3;
                default: next_q.rdata = 8'h00;
            endcase
        end

        // Writes are taken in every pair state
        if (reg_wr_i) begin
            case (reg_addr_i)
                A_CTL1: begin
                    // Reserved format codes leave the format unchanged
                    next_q.ctl1 = reg_wdata_i & CTL1_MASK;
                    if (reg_wdata_i[CTL1_FMT_LSB +: 4] >= FMT_RSVD_MIN) begin
                        next_q.ctl1[CTL1_FMT_LSB +: 4] = q.ctl1[CTL1_FMT_LSB +: 4];
                    end
                end
                A_CTL2: next_q.ctl2 = reg_wdata_i;
                A_PHASE: next_q.phase = reg_wdata_i;
                A_MUTE: next_q.mute = reg_wdata_i;
                A_CTL3: next_q.ctl3 = reg_wdata_i;
                default: next_q.rdata = next_q.rdata;
            endcase
        end

        // Mode-register reset restores defaults, wins over a write
        if (mode_reset_i) begin
            next_q.ctl1 = RST_CTL1;
            next_q.ctl2 = RST_CTL2;
            next_q.phase = RST_PHASE;
            next_q.mute = RST_MUTE;
            next_q.ctl3 = RST_CTL3;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            q <= '{ctl1: RST_CTL1, ctl2: RST_CTL2, phase: RST_PHASE, mute: RST_MUTE,
                ctl3: RST_CTL3, zero_stat: 8'h00, z_a: 8'h00, z_b: 8'h00, z_c: 8'h00,
                tg_a: 1'b0, tg_b: 1'b0, tg_c: 1'b0, tg_seen: 1'b0, step_cnt: 8'h00,
                cur: {8{ATT_FULL}}, tgt: {8{ATT_FULL}}, pair: {4{P_RUN}},
                rdata: 8'h00, rvalid: 1'b0, pin: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    // Format and control fields straight from registers
    assign dac_format_select_o = dcb_fmt_e'(q.ctl1[CTL1_FMT_LSB +: 4]);
    assign dac_powersave_select_o = q.ctl1[CTL1_PS_BIT];
    assign rolloff_select_o = q.ctl2[CTL2_FLT_LSB +: 4];
    assign dac_phase_invert_o = q.phase;
    assign deemphasis_select_o = q.ctl3[CTL3_DEEMPHASIS_SELECT_LSB +: 2];
    assign dac_atten_gain_o = q.cur;
    assign reg_rdata_o = q.rdata;
    assign reg_rvalid_o = q.rvalid;
    assign silence_pin_o = q.pin;

    // Hold level of a stopped pair
    for (genvar p = 0; p < 4; p++) begin : g_pair
        assign pair_off_o[p] = q.pair[p] == P_OFF;
        assign dac_common_mode_level_o[p] = pair_off_o[p] && q.ctl1[CTL1_PS_BIT];
        assign dac_analog_ground_o[p] = pair_off_o[p] && !q.ctl1[CTL1_PS_BIT];
        assign pair_power_down_o[p] = pair_off_o[p] && !q.ctl1[CTL1_PS_BIT];
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_fmt_written: assert property (
        reg_wr_i && !mode_reset_i && reg_addr_i == A_CTL1 && reg_wdata_i[3:0] < FMT_RSVD_MIN
        |=> dac_format_select_o == $past(reg_wdata_i[3:0]))
        else $error("format not taken from write");
    a_fmt_reserved: assert property (
        reg_wr_i && !mode_reset_i && reg_addr_i == A_CTL1 && reg_wdata_i[3:0] >= FMT_RSVD_MIN
        |=> $stable(dac_format_select_o))
        else $error("reserved format code was stored");
    a_fade_start: assert property (
        q.pair[0] == P_RUN && q.ctl2[CTL2_DIS_LSB] |=> q.pair[0] == P_FADE_OUT)
        else $error("pair did not start fade-out");
    a_off_cleared: assert property (
        pair_off_o[0] |=> dac_atten_gain_o[0] == ATT_ZERO && dac_atten_gain_o[1] == ATT_ZERO)
        else $error("stopped pair data not cleared");
    a_hold_level: assert property (
        pair_off_o[0] |-> dac_common_mode_level_o[0] == dac_powersave_select_o
        && dac_analog_ground_o[0] == !dac_powersave_select_o
        && pair_power_down_o[0] == !dac_powersave_select_o)
        else $error("stopped pair hold level wrong");
    a_fade_in: assert property (
        q.pair[3] == P_OFF && !q.ctl2[CTL2_DIS_LSB + 3] |=> q.pair[3] == P_FADE_IN)
        else $error("pair did not resume with fade-in");
    a_write_while_off: assert property (
        |pair_off_o && reg_wr_i && !mode_reset_i && reg_addr_i == A_PHASE
        |=> dac_phase_invert_o == $past(reg_wdata_i))
        else $error("write lost while pair stopped");
    a_mode_defaults: assert property (
        mode_reset_i |=> dac_phase_invert_o == RST_PHASE && q.ctl2 == RST_CTL2
        && deemphasis_select_o == 2'b00)
        else $error("mode reset left a register set");
    a_mute_target: assert property (
        q.mute[0] && q.cur[0] == q.tgt[0] && q.pair[0] != P_OFF |=> q.tgt[0] == ATT_ZERO)
        else $error("mute did not override level");
    a_ramp_step: assert property (
        step_due && q.cur[0] > q.tgt[0] && q.pair[0] != P_OFF
        |=> q.cur[0] == $past(q.cur[0]) - 8'h01)
        else $error("attenuator step wrong");
    a_zero_read: assert property (
        reg_rd_i && reg_addr_i == A_ZERO |=> reg_rvalid_o && reg_rdata_o == $past(q.zero_stat))
        else $error("zero flag read wrong");
    a_pin_high: assert property (
        (q.zero_stat == 8'hFF && q.ctl3[3:0] == 4'h0)[*2] |-> silence_pin_o)
        else $error("zero pin not high on detection");
    a_roll_written: assert property (
        reg_wr_i && !mode_reset_i && reg_addr_i == A_CTL2
        |=> rolloff_select_o == $past(reg_wdata_i[3:0]))
        else $error("roll-off not taken from write");
    a_mute_written: assert property (
        reg_wr_i && !mode_reset_i && reg_addr_i == A_MUTE |=> q.mute == $past(reg_wdata_i))
        else $error("mute bits not taken from write");
    a_deemphasis_select_written: assert property (
        reg_wr_i && !mode_reset_i && reg_addr_i == A_CTL3
        |=> deemphasis_select_o == $past(reg_wdata_i[5:4]))
        else $error("de-emphasis not taken from write");
    // Gains move only on a step, so the step rate alone sets the ramp time
    a_step_hold: assert property (
        !step_due && q.pair[0] != P_OFF |=> q.cur[0] == $past(q.cur[0]))
        else $error("attenuator moved between steps");
    a_ground_hold: assert property (
        pair_off_o[3] && !dac_powersave_select_o
        |-> dac_analog_ground_o[3] && pair_power_down_o[3] && !dac_common_mode_level_o[3])
        else $error("stopped pair not grounded");

    c_pair_off: cover property (q.pair[0] == P_FADE_OUT ##1 q.pair[0] == P_OFF);
    c_pair_resume: cover property (q.pair[0] == P_FADE_IN ##1 q.pair[0] == P_RUN);
    c_mute_ramp: cover property (q.mute[0] && step_due && q.cur[0] != ATT_ZERO);
    c_zero_pin: cover property ($rose(silence_pin_o));
    c_slow_ramp: cover property (q.ctl3[CTL3_SPEED_BIT] && step_due && q.cur[0] != q.tgt[0]);

endmodule : dcb_bank

// *** sim/dcb_link_model.sv ***
// Far-side audio link model: one frame pulse per sample, zero-detect levels.
// Assumes a free-running link clock from the bench; a sample every 4 link cycles.
`timescale 1ns/1ps
module dcb_link_model (
    input wire logic link_clk_i,
    input wire logic [7:0] zero_i,
    output logic link_frame_o,
    output logic [7:0] zero_det_o
);
    logic [1:0] div = 2'h0;
    initial link_frame_o = 1'b0;
    initial zero_det_o = 8'h00;
    // Sample clock runs free; 12 core cycles apart, so frames never merge
    always @(posedge link_clk_i) begin
        div <= div + 2'h1;
        link_frame_o <= (div == 2'h3);
        zero_det_o <= zero_i;
    end
endmodule : dcb_link_model

// *** sim/testbench.sv ***
// Self-checking bench for the DAC channel control bank.
// Assumes the link model on a 15 ns link clock; ramps shortened to 256 samples.
`timescale 1ns/1ps
module testbench;
    import dcb_pkg::*;
    logic core_clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst_i = 1'b1;
    logic mode_rst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] zin = 8'h00;
    dcb_rate_e rate = RATE_SINGLE;
    dcb_ratio_e ratio = RATIO_512;
    dcb_code_t [8:0] lvl;
    logic frame;
    logic [7:0] zdet, rdata, phase;
    logic rvalid, ps, pin;
    dcb_fmt_e fmt;
    logic [3:0] roll, off, cm, gnd, pd;
    logic [1:0] deemphasis_select;
    dcb_code_t [7:0] gain;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;

    always #2.5 core_clk_i = ~core_clk_i;
    // Offset start keeps the link clock out of phase with the core
    initial begin
        #1.3;
        forever #7.5 link_clk = ~link_clk;
    end

    dcb_link_model link (.link_clk_i(link_clk), .zero_i(zin), .link_frame_o(frame),
        .zero_det_o(zdet));

    dcb_bank #(.RAMP_SAMPLES(256)) DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .link_clk_i(link_clk), .link_frame_i(frame), .zero_det_i(zdet),
        .mode_reset_i(mode_rst), .dac_rate_mode_i(rate), .clk_ratio_i(ratio),
        .dac_atten_level_i(lvl), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .dac_format_select_o(fmt), .dac_powersave_select_o(ps), .rolloff_select_o(roll),
        .dac_phase_invert_o(phase), .deemphasis_select_o(deemphasis_select),
        .dac_atten_gain_o(gain), .pair_off_o(off), .dac_common_mode_level_o(cm),
        .dac_analog_ground_o(gnd), .pair_power_down_o(pd), .silence_pin_o(pin));

    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Ramp length must be twice the base within ten percent
    task automatic chk_twice(input int t, input int t0);
        n_compared++;
        if (t * 10 < t0 * 18 || t * 10 > t0 * 22) begin
            n_mismatch++;
            $display("MISMATCH t=%0t ramp %0d vs base %0d", $time, t, t0);
        end
    endtask : chk_twice

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge core_clk_i);
        wr = 1'b0;
        @(negedge core_clk_i);
    endtask : wr_reg

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        @(negedge core_clk_i);
        rd = 1'b1;
        addr = a;
        @(negedge core_clk_i);
        rd = 1'b0;
        chk(8'(rvalid), 8'h01);
        chk(rdata, e);
    endtask : rd_chk

    task automatic wait_gain(input int ch, input dcb_code_t v, output int t);
        t = 0;
        while (gain[ch] !== v && t < 20000) begin
            @(negedge core_clk_i);
            t++;
        end
        chk(gain[ch], v);
    endtask : wait_gain

    task automatic mute_time(output int t);
        int u;
        wr_reg(A_MUTE, 8'h01);
        wait_gain(0, ATT_ZERO, t);
        chk(gain[1], 8'hFF);
        wr_reg(A_MUTE, 8'h00);
        wait_gain(0, 8'hF0, u);
    endtask : mute_time

    initial begin
        int t0, t1, i;
        lvl = {9{8'hFF}};
        lvl[1] = 8'hF0;
        repeat (6) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        for (i = 1; i <= 7; i++) begin
            rd_chk(7'h40 + 7'(i), 8'h00);
        end
        wr_reg(A_PHASE, 8'hA5);
        chk(phase, 8'hA5);
        rd_chk(A_PHASE, 8'hA5);
        for (i = 0; i < 10; i++) begin
            wr_reg(A_CTL1, 8'(i));
            chk(8'(fmt), 8'(i));
        end
        wr_reg(A_CTL1, 8'h8A);
        chk(8'(fmt), 8'h09);
        chk(8'(ps), 8'h01);
        rd_chk(A_CTL1, 8'h89);
        wr_reg(A_CTL2, 8'h09);
        chk(8'(roll), 8'h09);
        wr_reg(A_CTL2, 8'h00);
        zin = 8'h5A;
        repeat (40) @(negedge core_clk_i);
        rd_chk(A_ZERO, 8'h5A);
        wr_reg(A_ZERO, 8'h00);
        rd_chk(A_ZERO, 8'h5A);
        zin = 8'hFF;
        repeat (40) @(negedge core_clk_i);
        chk(8'(pin), 8'h01);
        wr_reg(A_CTL3, 8'h31);
        repeat (4) @(negedge core_clk_i);
        chk(8'(pin), 8'h00);
        chk(8'(deemphasis_select), 8'h03);
        wr_reg(A_CTL3, 8'h02);
        zin = 8'h02;
        repeat (40) @(negedge core_clk_i);
        chk(8'(pin), 8'h00);
        zin = 8'h03;
        repeat (40) @(negedge core_clk_i);
        chk(8'(pin), 8'h01);
        wr_reg(A_CTL3, 8'h00);
        wait_gain(0, 8'hF0, t0);
        chk(gain[1], 8'hFF);
        lvl[0] = 8'hF0;
        wr_reg(A_CTL3, 8'h80);
        wait_gain(0, 8'hE1, t0);
        wr_reg(A_CTL3, 8'h00);
        wait_gain(0, 8'hF0, t0);
        mute_time(t0);
        wr_reg(A_CTL3, 8'h40);
        mute_time(t1);
        chk_twice(t1, t0);
        wr_reg(A_CTL3, 8'h00);
        rate = RATE_DUAL;
        mute_time(t1);
        chk_twice(t1, t0);
        rate = RATE_AUTO;
        ratio = RATIO_256;
        mute_time(t1);
        chk_twice(t1, t0);
        rate = RATE_SINGLE;
        wr_reg(A_CTL1, 8'h00);
        wr_reg(A_CTL2, 8'h90);
        wait_gain(0, ATT_ZERO, t1);
        wait_gain(7, ATT_ZERO, t1);
        // host waits out the power transition
        repeat (20) @(negedge core_clk_i);
        chk(8'(off), 8'h09);
        chk(gain[2], 8'hFF);
        chk(8'(gnd), 8'h09);
        chk(8'(pd), 8'h09);
        wr_reg(A_PHASE, 8'h3C);
        rd_chk(A_PHASE, 8'h3C);
        wr_reg(A_CTL1, 8'h80);
        repeat (20) @(negedge core_clk_i);
        chk(8'(cm), 8'h09);
        chk(8'(gnd), 8'h00);
        wr_reg(A_CTL2, 8'h00);
        wait_gain(0, 8'hF0, t1);
        wait_gain(1, 8'hFF, t1);
        repeat (20) @(negedge core_clk_i);
        chk(8'(off), 8'h00);
        wr_reg(A_CTL3, 8'h30);
        mode_rst = 1'b1;
        @(negedge core_clk_i);
        mode_rst = 1'b0;
        rd_chk(A_PHASE, 8'h00);
        rd_chk(A_CTL1, 8'h00);
        rd_chk(A_CTL3, 8'h00);
        print_verdict();
    end
endmodule : testbench
